// ==== logic/gfes_pkg.sv ====
// Purpose: Shared constants for the shadowed general register file
// Assumes: One core clock, APB register access
// Notes:   Offsets are byte addresses of 32-bit words
package gfes_pkg;
  // ==========================================================
  // Register map
  localparam logic [11:0] GFES_OFF_SHADOW_CTL = 12'h000;
  localparam logic [11:0] GFES_OFF_STATUS     = 12'h004;
  localparam logic [11:0] GFES_OFF_XLAT_LO    = 12'h008;
  localparam logic [11:0] GFES_OFF_XLAT_HI    = 12'h00C;
  // ==========================================================
  // Field positions
  localparam int GFES_CSS_LSB     = 0;
  localparam int GFES_FLIP_BIT    = 0;
  localparam int GFES_USER_BIT    = 1;
  localparam int GFES_MEMORD_BIT  = 2;
  localparam int GFES_LSORD_BIT   = 3;
  localparam int GFES_FCC0_BIT    = 4;
  // ==========================================================
  // Reset values
  localparam logic [3:0]  GFES_CSS_RST    = 4'h0;
  localparam logic [31:0] GFES_XLAT_LO_RST = 32'h7654_3210;
  localparam logic [31:0] GFES_XLAT_HI_RST = 32'hFEDC_BA98;
endpackage : gfes_pkg

// ==== logic/gfes_shift.sv ====
// Purpose: Zero-fill left and right shifter
// Assumes: Amount below data width
// Notes:   Never replicates the sign bit
`timescale 1ns/1ns
module gfes_shift #(
  parameter int W = 32
) (
  // Operand
  input  wire logic [W-1:0]         din,
  input  wire logic [$clog2(W)-1:0] amt,
  input  wire logic                 dir_right,
  // Result
  output logic      [W-1:0]         dout
);
  always_comb begin
    if (dir_right) begin
      dout = din >> amt; // RQ5
    end else begin
      dout = din << amt; // RQ4
    end
  end
endmodule : gfes_shift

// ==== logic/gfes_regfile.sv ====
// Purpose: Shadowed general register file with byte-order selection
// Assumes: Pipeline ports synchronous to pclk; APB for control
// Notes:   Reads are registered, one cycle after request
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ns
// Notes on behaviour
// RQ1: Register zero always reads zero and writes to it are dropped.
// RQ2: Every register is 32 or 64 bits wide, set by one parameter.
// RQ3: All accesses use the bank chosen by the current shadow set field.
// RQ4: Left shift fills zeros at the low end.
// RQ5: Right shift fills zeros at the high end.
// RQ6: Memory byte order is captured at reset, 0 little and 1 big.
// RQ7: Load/store byte order is memory order xor user order flip.
// RQ8: User order flip is high only with the flip bit set in user mode.
// RQ9: Floating condition flag 0 equals the coprocessor 1 condition signal.
// RQ10: Compressed register numbers translate through a settable table.
module gfes_regfile
  import gfes_pkg::*;
#(
  parameter int REGISTER_WIDTH = 32,
  parameter int NUM_SETS       = 4,
  parameter int NUM_REGS       = 32
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Mode and strap inputs
  input  wire logic                        memory_byte_order_strap,
  input  wire logic                        user_mode,
  input  wire logic                        coprocessor_condition_signal,
  // Pipeline read port
  input  wire logic                        rd_en,
  input  wire logic                        rd_compressed,
  input  wire logic [4:0]                  rd_addr,
  output logic      [REGISTER_WIDTH-1:0]   rd_data,
  // Pipeline write port
  input  wire logic                        wr_en,
  input  wire logic [4:0]                  wr_addr,
  input  wire logic [REGISTER_WIDTH-1:0]   wr_data,
  // Shifter port
  input  wire logic [REGISTER_WIDTH-1:0]   sh_data,
  input  wire logic [$clog2(REGISTER_WIDTH)-1:0] sh_amt,
  input  wire logic                        sh_right,
  output logic      [REGISTER_WIDTH-1:0]   sh_result,
  // Order and flag outputs
  output logic                             memory_byte_order,
  output logic                             user_order_flip,
  output logic                             load_store_byte_order,
  output logic                             fp_condition_flag0
);
  localparam int SW = $clog2(NUM_SETS);

  // ==========================================================
  // Storage and control state
  logic [REGISTER_WIDTH-1:0] shadow_register_bank [NUM_SETS][NUM_REGS];
  logic [3:0]                shadow_set_control_r;
  logic                      user_byte_order_flip_bit_r;
  logic                      strap_pending_r;
  logic [31:0]               xlat_lo_r;
  logic [31:0]               xlat_hi_r;
  logic [REGISTER_WIDTH-1:0] sh_nxt;
  logic [SW-1:0]             current_shadow_set;
  logic [4:0]                rd_phys;
  logic [2:0]                xl_idx;
  logic                      order_now;
  logic                      flip_now;

  // Caught at elaboration so a bad build stops before any logic exists
  generate
    if (REGISTER_WIDTH != 32 && REGISTER_WIDTH != 64) begin : g_bad_width
      $error("register width must be 32 or 64"); // RQ2
    end
    // A single set would leave the set index with no bits
    if (NUM_SETS < 2 || NUM_SETS > 16) begin : g_bad_sets
      $error("shadow set count must be 2 to 16");
    end
  endgenerate

  assign current_shadow_set = shadow_set_control_r[SW-1:0]; // RQ3
  assign xl_idx = rd_addr[2:0];

  // ==========================================================
  // Compressed register number lookup
  // Table reaches registers 0 to 15 only
  always_comb begin
    logic [3:0] ent;
    ent = 4'h0;
    if (xl_idx[2]) begin
      ent = xlat_hi_r[4*xl_idx[1:0] +: 4];
    end else begin
      ent = xlat_lo_r[4*xl_idx[1:0] +: 4];
    end
    rd_phys = rd_compressed ? {1'b0, ent} : rd_addr; // RQ10
  end

  // ==========================================================
  // Register writes
  // Storage has no reset, which keeps reset fan-out off the array
  always_ff @(posedge pclk) begin
    if (wr_en && wr_addr != 5'd0) begin // RQ1
      shadow_register_bank[current_shadow_set][wr_addr] <= wr_data; // RQ3
    end
  end

  // Read, registered
  // Entry zero is forced on read, so it never depends on the array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      if (rd_phys == 5'd0) begin
        rd_data <= '0; // RQ1
      end else begin
        rd_data <= shadow_register_bank[current_shadow_set][rd_phys]; // RQ3
      end
    end
  end

  // ==========================================================
  // Shifter
  // Result registered so the output comes straight from a flip-flop
  gfes_shift #(.W(REGISTER_WIDTH)) u_shift (
    .din       (sh_data),
    .amt       (sh_amt),
    .dir_right (sh_right),
    .dout      (sh_nxt)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_result <= '0;
    end else begin
      sh_result <= sh_nxt; // RQ4 RQ5
    end
  end

  // ==========================================================
  // Byte order; strap caught on first edge after reset release
  // Strap motion after that edge is ignored until the next reset
  assign order_now = strap_pending_r ? memory_byte_order_strap : memory_byte_order; // RQ6
  assign flip_now  = user_byte_order_flip_bit_r & user_mode; // RQ8

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_pending_r   <= 1'b1;
      memory_byte_order <= 1'b0;
    end else if (strap_pending_r) begin
      strap_pending_r   <= 1'b0;
      memory_byte_order <= memory_byte_order_strap; // RQ6
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_order_flip       <= 1'b0;
      load_store_byte_order <= 1'b0;
      fp_condition_flag0    <= 1'b0;
    end else begin
      user_order_flip       <= flip_now; // RQ8
      // Same flip_now input as the flip output, so both change on one edge
      load_store_byte_order <= order_now ^ flip_now; // RQ7
      fp_condition_flag0    <= coprocessor_condition_signal; // RQ9
    end
  end

  // ==========================================================
  // APB slave, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_set_control_r       <= GFES_CSS_RST;
      user_byte_order_flip_bit_r <= 1'b0;
      xlat_lo_r                  <= GFES_XLAT_LO_RST;
      xlat_hi_r                  <= GFES_XLAT_HI_RST;
    end else if (psel && penable && pwrite) begin
      unique case (paddr)
        GFES_OFF_SHADOW_CTL: shadow_set_control_r <= pwdata[GFES_CSS_LSB +: 4];
        GFES_OFF_STATUS:     user_byte_order_flip_bit_r <= pwdata[GFES_FLIP_BIT];
        GFES_OFF_XLAT_LO:    xlat_lo_r <= pwdata;
        GFES_OFF_XLAT_HI:    xlat_hi_r <= pwdata;
        // Unmapped writes are dropped; the error flag comes from the read side
        default: begin
        end
      endcase
    end
  end

  // Read data decoded at setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        unique case (paddr)
          GFES_OFF_SHADOW_CTL: prdata <= {28'h000_0000, shadow_set_control_r};
          GFES_OFF_STATUS: begin
            prdata[GFES_FLIP_BIT]   <= user_byte_order_flip_bit_r;
            prdata[GFES_USER_BIT]   <= user_mode;
            prdata[GFES_MEMORD_BIT] <= memory_byte_order;
            prdata[GFES_LSORD_BIT]  <= load_store_byte_order;
            prdata[GFES_FCC0_BIT]   <= fp_condition_flag0;
          end
          GFES_OFF_XLAT_LO: prdata <= xlat_lo_r;
          GFES_OFF_XLAT_HI: prdata <= xlat_hi_r;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : gfes_regfile

// ==== tb/gfes_regfile_sva.sv ====
// Purpose: Port assertions for gfes_regfile
// Assumes: One pclk domain, async presetn
// Notes:   Bound to every instance
`timescale 1ns/1ns
module gfes_regfile_sva #(parameter int REGISTER_WIDTH = 32) (
  // Clock, reset, bus handshake, modes
  input wire logic pclk, presetn, psel, penable, pready, sh_right, user_mode,
  input wire logic coprocessor_condition_signal, memory_byte_order, user_order_flip,
  input wire logic load_store_byte_order, fp_condition_flag0,
  // Shifter
  input wire logic [REGISTER_WIDTH-1:0]         sh_data, sh_result,
  input wire logic [$clog2(REGISTER_WIDTH)-1:0] sh_amt
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  shift_left_a: assert property (!sh_right |=> sh_result == $past(sh_data) << $past(sh_amt))
    else $error("bad left shift");
  shift_right_a: assert property (sh_right |=> sh_result == $past(sh_data) >> $past(sh_amt))
    else $error("bad right shift");
  order_hold_a: assert property ($past(presetn, 2) |-> $stable(memory_byte_order))
    else $error("memory order moved");
  // Flip must be steady so a one-cycle lag in either reading is tolerated
  order_xor_a: assert property ($past(presetn, 2) && $stable(user_order_flip) |->
    load_store_byte_order == (memory_byte_order ^ user_order_flip)) else $error("bad order");
  flip_user_a: assert property (user_order_flip |-> $past(user_mode))
    else $error("flip outside user mode");
  cond_copy_a: assert property ($past(presetn) |->
    fp_condition_flag0 == $past(coprocessor_condition_signal)) else $error("flag differs");
endmodule : gfes_regfile_sva

bind gfes_regfile gfes_regfile_sva #(.REGISTER_WIDTH(REGISTER_WIDTH)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .sh_right(sh_right), .user_mode(user_mode),
  .coprocessor_condition_signal(coprocessor_condition_signal),
  .memory_byte_order(memory_byte_order), .user_order_flip(user_order_flip),
  .load_store_byte_order(load_store_byte_order), .fp_condition_flag0(fp_condition_flag0),
  .sh_data(sh_data), .sh_result(sh_result), .sh_amt(sh_amt)
);

// ==== tb/gfes_pipe_model.sv ====
// Purpose: Pipeline model issuing register traffic
// Assumes: Bench queues each request one cycle ahead
// Notes:   No reset; bench holds requests low in reset
`timescale 1ns/1ns
module gfes_pipe_model #(parameter int W = 64) (
  // Bench requests
  input  wire logic         pclk, q_rd, q_wr, q_comp,
  input  wire logic [4:0]   q_addr,
  input  wire logic [W-1:0] q_data,
  // Register file pipeline side
  output logic              rd_en, rd_compressed, wr_en,
  output logic [4:0]        rd_addr, wr_addr,
  output logic [W-1:0]      wr_data
);
  // Idle address and data lines carry inverted values so a stale copy is never mistaken for data
  always_ff @(posedge pclk) begin
    rd_en <= q_rd;
    wr_en <= q_wr;
    rd_compressed <= q_comp;
    rd_addr <= q_rd ? q_addr : ~q_addr;
    wr_addr <= q_wr ? q_addr : ~q_addr;
    wr_data <= q_wr ? q_data : ~q_data;
  end
endmodule : gfes_pipe_model

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for gfes_regfile
// Assumes: 125 MHz pclk, seed 44, 64-bit registers
// Notes:   Pipeline traffic goes through gfes_pipe_model
`timescale 1ns/1ns
module tb;
  import gfes_pkg::*;
  localparam int W = 64;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, sh_right, mo;
  logic memory_byte_order_strap, user_mode, coprocessor_condition_signal;
  logic rd_en, rd_compressed, wr_en, q_rd, q_wr, q_comp;
  logic memory_byte_order, user_order_flip, load_store_byte_order, fp_condition_flag0;
  logic [4:0]   rd_addr, wr_addr, q_addr;
  logic [5:0]   sh_amt;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rv;
  logic [W-1:0] rd_data, wr_data, q_data, sh_data, sh_result, v, ex [4];
  int n_mismatch = 0, check_count = 0, seed = 44, cyc = 0;
  gfes_regfile #(.REGISTER_WIDTH(W)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memory_byte_order_strap(memory_byte_order_strap), .user_mode(user_mode),
    .coprocessor_condition_signal(coprocessor_condition_signal),
    .rd_en(rd_en), .rd_compressed(rd_compressed), .rd_addr(rd_addr), .rd_data(rd_data),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .sh_data(sh_data), .sh_amt(sh_amt), .sh_right(sh_right), .sh_result(sh_result),
    .memory_byte_order(memory_byte_order), .user_order_flip(user_order_flip),
    .load_store_byte_order(load_store_byte_order), .fp_condition_flag0(fp_condition_flag0)
  );
  gfes_pipe_model #(.W(W)) u_pipe (
    .pclk(pclk), .q_rd(q_rd), .q_wr(q_wr), .q_comp(q_comp), .q_addr(q_addr),
    .q_data(q_data), .rd_en(rd_en), .rd_compressed(rd_compressed), .wr_en(wr_en),
    .rd_addr(rd_addr), .wr_addr(wr_addr), .wr_data(wr_data)
  );
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [W-1:0] shx(logic [W-1:0] d, logic [5:0] a, logic r);
    return r ? d >> a : d << a;
  endfunction : shx
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rv = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Idle edge so a following call never drives psel twice in one step
    @(posedge pclk);
  endtask : apb
  task automatic pipe(input logic w, c, input logic [4:0] a, input logic [W-1:0] d);
    q_wr <= w;
    q_rd <= !w;
    q_comp <= c;
    q_addr <= a;
    q_data <= d;
    @(posedge pclk);
    {q_wr, q_rd} <= 2'h0;
    repeat (2) @(posedge pclk);
    v = rd_data;
  endtask : pipe
  // ==========================================================
  // Scenarios
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, q_rd, q_wr, q_comp, q_addr, q_data} = '0;
    {user_mode, coprocessor_condition_signal, sh_right, sh_amt, sh_data} = '0;
    memory_byte_order_strap = 1'($random(seed));
    mo = memory_byte_order_strap;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    memory_byte_order_strap <= ~mo;
    for (int m = 0; m < 4; m++) begin
      user_mode <= m[0];
      apb(1'h1, GFES_OFF_STATUS, {31'h0, m[1]});
      repeat (2) @(posedge pclk);
      chk(memory_byte_order, mo);
      chk(user_order_flip, m[0] & m[1]);
      chk(load_store_byte_order, mo ^ m[0] & m[1]);
    end
    apb(1'h0, GFES_OFF_STATUS, 32'h0);
    chk(err, 1'h0);
    chk(rv, {27'h0, 1'h0, mo ^ 1'h1, mo, 2'h3});
    apb(1'h0, 12'h010, 32'h0);
    chk(err, 1'h1);
    chk(rv, '0);
    // Compressed number 3 steered onto register 5
    apb(1'h1, GFES_OFF_XLAT_LO, 32'h7654_5210);
    apb(1'h0, GFES_OFF_XLAT_LO, 32'h0);
    chk(rv, 32'h7654_5210);
    for (int s = 0; s < 8; s++) begin
      apb(1'h1, GFES_OFF_SHADOW_CTL, 32'(s % 4));
      if (s < 4) begin
        ex[s] = {$random(seed), $random(seed)};
        pipe(1'h1, 1'h0, 5'h05, ex[s]);
        pipe(1'h1, 1'h0, 5'h00, ~ex[s]);
      end else begin
        pipe(1'h0, 1'h0, 5'h00, '0);
        chk(v, '0);
        pipe(1'h0, 1'(s), s[0] ? 5'h03 : 5'h05, '0);
        chk(v, ex[s % 4]);
      end
    end
    for (int i = 0; i < 40; i++) begin
      sh_data <= (i < 4) ? '1 : {$random(seed), $random(seed)};
      sh_amt <= (i < 4) ? {6{i[0]}} : 6'($random(seed));
      sh_right <= (i < 4) ? i[1] : 1'($random(seed));
      coprocessor_condition_signal <= 1'($random(seed));
      repeat (2) @(posedge pclk);
      chk(sh_result, shx(sh_data, sh_amt, sh_right));
      chk(fp_condition_flag0, coprocessor_condition_signal);
    end
    conclude();
  end
endmodule : tb
